// ===== logic/dbgtr_pkg.sv
package dbgtr_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the wishbone slave)
  // ----------------------------------------------------------------
  localparam logic [7:0] DBGTR_OFS_CONTROL = 8'h00;
  localparam logic [7:0] DBGTR_OFS_TRIGGER = 8'h04;
  localparam logic [7:0] DBGTR_OFS_STATUS = 8'h08;
  localparam logic [7:0] DBGTR_REG_RESET = 8'h00;
  localparam logic [7:0] DBGTR_TRG_WR_MASK = 8'hcf;

  // debug_control fields
  localparam int DBGTR_CTL_EN = 7;
  localparam int DBGTR_CTL_ARM = 6;
  localparam int DBGTR_CTL_TAG = 5;
  localparam int DBGTR_CTL_BRK = 4;
  localparam int DBGTR_CTL_RWA = 3;
  localparam int DBGTR_CTL_RWAEN = 2;
  localparam int DBGTR_CTL_RWB = 1;
  localparam int DBGTR_CTL_RWBEN = 0;

  // trigger_control fields
  localparam int DBGTR_TRG_QSEL = 7;
  localparam int DBGTR_TRG_BEGIN = 6;
  localparam int DBGTR_TRG_MODE_MSB = 3;

  // debug_status fields
  localparam int DBGTR_STS_AHIT = 7;
  localparam int DBGTR_STS_BHIT = 6;
  localparam int DBGTR_STS_ARMED = 5;

  // capture sizing
  localparam int DBGTR_ADDR_W = 16;
  localparam int DBGTR_CNT_W = 4;
  localparam logic [3:0] DBGTR_FIFO_DEPTH = 4'h8;
  localparam logic [7:0] DBGTR_HIGH_UNUSED = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    DBGTR_MODE_A_ONLY = 4'h0,
    DBGTR_MODE_A_OR_B = 4'h1,
    DBGTR_MODE_A_THEN_B = 4'h2,
    DBGTR_MODE_EV_B = 4'h3,
    DBGTR_MODE_A_EV_B = 4'h4,
    DBGTR_MODE_A_AND_B = 4'h5,
    DBGTR_MODE_A_NAND_B = 4'h6,
    DBGTR_MODE_INSIDE = 4'h7,
    DBGTR_MODE_OUTSIDE = 4'h8
  } dbgtr_mode_t;

  typedef enum logic [2:0] {
    DBGTR_ST_IDLE = 3'b001,
    DBGTR_ST_WAIT = 3'b010,
    DBGTR_ST_STORE = 3'b100
  } dbgtr_state_t;

  // one observed cpu bus access
  typedef struct packed {
    logic valid;
    logic rd;
    logic [15:0] addr;
    logic [7:0] data;
  } dbgtr_bus_obs_t;

  // one word towards the capture fifo
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } dbgtr_fifo_wr_t;

endpackage

// ===== logic/dbgtr_tag_track.sv
`timescale 1ns/100ps
module dbgtr_tag_track
  import dbgtr_pkg::*;
#(
  parameter int AW = DBGTR_ADDR_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // qualification control
  input wire logic qualify,
  input wire logic clear,
  // raw comparator hit
  input wire logic hit,
  input wire logic [AW-1:0] hit_addr,
  // opcode execution report
  input wire logic exec_valid,
  input wire logic [AW-1:0] exec_addr,
  // qualified event
  output logic event_o
);

  logic pend_q, pend_d;
  logic [AW-1:0] addr_q, addr_d;
  logic tag_fire;

  // tag type fires only when the fetched opcode really executes
  assign tag_fire = pend_q && exec_valid && (exec_addr == addr_q);
  assign event_o = qualify ? tag_fire : hit;

  // a newer hit replaces the pending one; a flushed fetch never fires
  always_comb begin
    pend_d = pend_q;
    addr_d = addr_q;
    if (clear || !qualify) begin
      pend_d = 1'b0;
    end else if (hit) begin
      pend_d = 1'b1;
      addr_d = hit_addr;
    end else if (tag_fire) begin
      pend_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pend_q <= 1'b0;
      addr_q <= '0;
    end else begin
      pend_q <= pend_d;
      addr_q <= addr_d;
    end
  end

endmodule

// ===== logic/dbgtr_core.sv
// Function
// - trigger_control always readable, written only while unarmed; bits 5:4 read zero.
// - qualify select 1: comparator match triggers only once the opcode executes.
// - qualify select 0: trigger as soon as the compare address is accessed.
// - begin select 0 fills circularly until trigger; 1 starts storing at trigger.
// - event-only modes ignore begin select and always run as begin trace.
// - mode 0000 A only, 0001 A or B, 0010 A then B.
// - mode 0011 stores on B events; 0100 waits for A, then stores on B.
// - mode 0101 address A and data B; 0110 address A and data not B.
// - 0111 inside A..B, 1000 outside; 1001 to 1111 never trigger.
// - compare A hit flag clears at run start, sets on A condition while armed.
// - compare B hit flag clears at run start, sets on B condition while armed.
// - armed flag mirrors arm while enabled; arm write sets, run end clears.
// - run ends on full in begin trace, trigger in end trace, or software stop.
// - valid count clears at start, shows valid words at run end, 0 to 8.
// - valid count never decrements while the fifo is read out.
// - debug_status is read-only; writes change nothing.
// - event-only modes store the low byte only; high byte reads zero.
// - module enable cannot be set while the device is secure.
// - break enabled: end trace breaks on trigger, begin trace on fifo full.
`timescale 1ns/100ps
module dbgtr_core
  import dbgtr_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // observed cpu bus and opcode execution
  input wire dbgtr_bus_obs_t bus_obs,
  input wire logic exec_valid,
  input wire logic [15:0] exec_addr,
  // comparator values and security state
  input wire logic [15:0] cmp_a_val,
  input wire logic [15:0] cmp_b_val,
  input wire logic secure,
  // capture fifo and break request
  output dbgtr_fifo_wr_t fifo_wr,
  output logic brk_req,
  output logic brk_tag
);

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic ack_q, ack_d;
  logic [7:0] rdat_q, rdat_d;
  logic [7:0] ctl_q, ctl_d;
  logic [7:0] trg_q, trg_d;
  logic [7:0] status;
  logic req, wr_fire, wr_ctl, wr_trg;

  assign req = wb_cyc_i && wb_stb_i;
  // writes land on the edge where the master sees ack
  assign wr_fire = req && wb_we_i && ack_q && wb_sel_i[0];
  assign wr_ctl = wr_fire && (wb_adr_i == DBGTR_OFS_CONTROL);
  assign wr_trg = wr_fire && (wb_adr_i == DBGTR_OFS_TRIGGER);
  assign wb_ack_o = ack_q;
  assign wb_dat_o = {24'h000000, rdat_q};

  // one wait state; unmapped addresses answer with zero
  always_comb begin
    ack_d = req && !ack_q;
    rdat_d = rdat_q;
    if (req && !ack_q) begin
      unique case (wb_adr_i)
        DBGTR_OFS_CONTROL: rdat_d = ctl_q;
        DBGTR_OFS_TRIGGER: rdat_d = trg_q;
        DBGTR_OFS_STATUS: rdat_d = status;
        default: rdat_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      rdat_q <= DBGTR_REG_RESET;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // ----------------------------------------------------------------
  // comparator qualification
  // ----------------------------------------------------------------
  dbgtr_state_t st_q, st_d;
  dbgtr_mode_t mode;
  logic running, event_only, begin_mode;
  logic rwa_ok, rwb_ok, a_addr_eq, b_addr_eq, data_eq;
  logic a_raw, b_raw, a_ev, b_ev, trig;
  logic flush;

  assign mode = dbgtr_mode_t'(trg_q[DBGTR_TRG_MODE_MSB:0]);
  assign running = (st_q != DBGTR_ST_IDLE);
  assign event_only = (mode == DBGTR_MODE_EV_B) || (mode == DBGTR_MODE_A_EV_B);
  assign begin_mode = trg_q[DBGTR_TRG_BEGIN] || event_only;
  assign rwa_ok = !ctl_q[DBGTR_CTL_RWAEN] || (bus_obs.rd == ctl_q[DBGTR_CTL_RWA]);
  assign rwb_ok = !ctl_q[DBGTR_CTL_RWBEN] || (bus_obs.rd == ctl_q[DBGTR_CTL_RWB]);
  assign a_addr_eq = (bus_obs.addr == cmp_a_val);
  assign b_addr_eq = (bus_obs.addr == cmp_b_val);
  assign data_eq = (bus_obs.data == cmp_b_val[7:0]);

  // per-mode raw hits; unlisted codes never hit
  always_comb begin
    a_raw = 1'b0;
    b_raw = 1'b0;
    if (running && bus_obs.valid) begin
      unique case (trg_q[DBGTR_TRG_MODE_MSB:0])
        // A, A or B, A then B
        DBGTR_MODE_A_ONLY: a_raw = rwa_ok && a_addr_eq;
        DBGTR_MODE_A_OR_B, DBGTR_MODE_A_THEN_B: begin
          a_raw = rwa_ok && a_addr_eq;
          b_raw = rwb_ok && b_addr_eq;
        end
        DBGTR_MODE_EV_B: b_raw = rwb_ok && b_addr_eq;
        DBGTR_MODE_A_EV_B: begin
          a_raw = rwa_ok && a_addr_eq;
          b_raw = rwb_ok && b_addr_eq;
        end
        DBGTR_MODE_A_AND_B: a_raw = rwa_ok && a_addr_eq && data_eq;
        DBGTR_MODE_A_NAND_B: a_raw = rwa_ok && a_addr_eq && !data_eq;
        DBGTR_MODE_INSIDE: begin
          a_raw = rwa_ok && (bus_obs.addr >= cmp_a_val) && (bus_obs.addr <= cmp_b_val);
        end
        DBGTR_MODE_OUTSIDE: begin
          a_raw = rwa_ok && ((bus_obs.addr < cmp_a_val) || (bus_obs.addr > cmp_b_val));
        end
        default: a_raw = 1'b0;
      endcase
    end
  end

  // tag path through opcode tracking; force path is direct
  dbgtr_tag_track #(.AW(DBGTR_ADDR_W)) u_track_a (
    .clk_sys(clk_sys),
    .reset(reset),
    .qualify(trg_q[DBGTR_TRG_QSEL]),
    .clear(flush),
    .hit(a_raw),
    .hit_addr(bus_obs.addr),
    .exec_valid(exec_valid),
    .exec_addr(exec_addr),
    .event_o(a_ev)
  );

  dbgtr_tag_track #(.AW(DBGTR_ADDR_W)) u_track_b (
    .clk_sys(clk_sys),
    .reset(reset),
    .qualify(trg_q[DBGTR_TRG_QSEL]),
    .clear(flush),
    .hit(b_raw),
    .hit_addr(bus_obs.addr),
    .exec_valid(exec_valid),
    .exec_addr(exec_addr),
    .event_o(b_ev)
  );

  // ----------------------------------------------------------------
  // run control, flags and capture
  // ----------------------------------------------------------------
  logic ahit_q, ahit_d, bhit_q, bhit_d, seen_a_q, seen_a_d;
  logic [DBGTR_CNT_W-1:0] cnt_q, cnt_d;
  dbgtr_fifo_wr_t fwr_q, fwr_d;
  logic brk_q, brk_d;
  logic en_next, start, sw_stop, store, full_now, run_end;

  // enable refused while secure, unless already set
  assign en_next = wb_dat_i[DBGTR_CTL_EN] && (ctl_q[DBGTR_CTL_EN] || !secure);
  assign start = wr_ctl && !running && en_next && wb_dat_i[DBGTR_CTL_ARM];
  assign sw_stop = wr_ctl && running && !(en_next && wb_dat_i[DBGTR_CTL_ARM]);
  assign flush = !running || start;

  // trigger per mode; A then B remembers an earlier A
  always_comb begin
    unique case (trg_q[DBGTR_TRG_MODE_MSB:0])
      DBGTR_MODE_A_OR_B: trig = a_ev || b_ev;
      DBGTR_MODE_A_THEN_B: trig = b_ev && seen_a_q;
      DBGTR_MODE_A_ONLY, DBGTR_MODE_A_AND_B, DBGTR_MODE_A_NAND_B,
      DBGTR_MODE_INSIDE, DBGTR_MODE_OUTSIDE: trig = a_ev;
      default: trig = 1'b0;
    endcase
  end

  // stores every access in full modes; only B events when event-only
  assign store = (st_q == DBGTR_ST_STORE) && (event_only ? b_ev : bus_obs.valid);
  assign full_now = store && (cnt_q == DBGTR_FIFO_DEPTH - 4'h1);
  // the three ways a run ends
  assign run_end = sw_stop || (running && !begin_mode && trig) ||
                   (begin_mode && (full_now || (st_q == DBGTR_ST_STORE &&
                   cnt_q == DBGTR_FIFO_DEPTH)));

  always_comb begin
    st_d = st_q;
    ctl_d = ctl_q;
    trg_d = trg_q;
    ahit_d = ahit_q;
    bhit_d = bhit_q;
    seen_a_d = seen_a_q;
    cnt_d = cnt_q;
    fwr_d = '0;
    brk_d = 1'b0;
    if (wr_ctl) begin
      ctl_d = wb_dat_i[7:0];
      ctl_d[DBGTR_CTL_EN] = en_next;
      ctl_d[DBGTR_CTL_ARM] = en_next && wb_dat_i[DBGTR_CTL_ARM];
    end
    // locked while armed, bits 5:4 forced low
    if (wr_trg && !ctl_q[DBGTR_CTL_ARM]) begin
      trg_d = wb_dat_i[7:0] & DBGTR_TRG_WR_MASK;
    end
    // hits stick for the run; a set wins over nothing clearing mid-run
    if (running) begin
      ahit_d = ahit_q || a_ev;
      bhit_d = bhit_q || b_ev;
      seen_a_d = seen_a_q || a_ev;
    end
    if (store) begin
      // saturates at the fifo depth in circular fill
      if (cnt_q != DBGTR_FIFO_DEPTH) begin
        cnt_d = cnt_q + 4'h1;
      end
      fwr_d.valid = 1'b1;
      // event-only keeps the high byte empty
      fwr_d.word = event_only ? {DBGTR_HIGH_UNUSED, bus_obs.data} : bus_obs.addr;
    end
    unique case (st_q)
      DBGTR_ST_IDLE: begin
        if (start) begin
          // run start clears flags and count
          ahit_d = 1'b0;
          bhit_d = 1'b0;
          seen_a_d = 1'b0;
          cnt_d = '0;
          if (!begin_mode || mode == DBGTR_MODE_EV_B) begin
            st_d = DBGTR_ST_STORE;
          end else begin
            st_d = DBGTR_ST_WAIT;
          end
        end
      end
      DBGTR_ST_WAIT: begin
        if ((mode == DBGTR_MODE_A_EV_B) ? a_ev : trig) begin
          st_d = DBGTR_ST_STORE;
        end
      end
      DBGTR_ST_STORE: st_d = DBGTR_ST_STORE;
      default: st_d = DBGTR_ST_IDLE;
    endcase
    // end of run drops arm and with it the armed flag
    if (run_end && running) begin
      st_d = DBGTR_ST_IDLE;
      ctl_d[DBGTR_CTL_ARM] = 1'b0;
      // break on trigger or on full
      brk_d = ctl_q[DBGTR_CTL_BRK] && !sw_stop;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_q <= DBGTR_ST_IDLE;
      ctl_q <= DBGTR_REG_RESET;
      trg_q <= DBGTR_REG_RESET;
      ahit_q <= 1'b0;
      bhit_q <= 1'b0;
      seen_a_q <= 1'b0;
      cnt_q <= '0;
      fwr_q <= '0;
      brk_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ctl_q <= ctl_d;
      trg_q <= trg_d;
      ahit_q <= ahit_d;
      bhit_q <= bhit_d;
      seen_a_q <= seen_a_d;
      cnt_q <= cnt_d;
      fwr_q <= fwr_d;
      brk_q <= brk_d;
    end
  end

  // status is assembled, never written; count only moves in a run
  assign status = {ahit_q, bhit_q, ctl_q[DBGTR_CTL_EN] && ctl_q[DBGTR_CTL_ARM],
                   1'b0, cnt_q};
  assign fifo_wr = fwr_q;
  assign brk_req = brk_q;
  assign brk_tag = ctl_q[DBGTR_CTL_TAG];

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  a_trg_write_lock: assert property (wr_trg && ctl_q[DBGTR_CTL_ARM] |=> $stable(trg_q))
    else $error("trigger_control changed while armed");
  a_trg_zero_bits: assert property (trg_q[5:4] == 2'b00)
    else $error("trigger_control bits 5:4 not zero");
  a_tag_needs_exec: assert property (trg_q[DBGTR_TRG_QSEL] && !exec_valid |-> !a_ev && !b_ev)
    else $error("tag trigger without execution");
  a_force_ends_run: assert property (st_q == DBGTR_ST_STORE && !begin_mode &&
      !trg_q[DBGTR_TRG_QSEL] && mode == DBGTR_MODE_A_ONLY && a_raw
      |=> st_q == DBGTR_ST_IDLE && !status[DBGTR_STS_ARMED])
    else $error("force trigger did not end run");
  a_start_clears: assert property (start |=> !ahit_q && !bhit_q && cnt_q == 4'h0 &&
      status[DBGTR_STS_ARMED])
    else $error("run start did not clear status");
  a_armed_mirror: assert property (status[DBGTR_STS_ARMED] == running)
    else $error("armed flag not mirroring arm");
  a_count_hold: assert property (!running && !start |=> $stable(cnt_q))
    else $error("valid count moved outside a run");
  a_status_ro: assert property (!running ##1 !start && !running |-> $stable(status))
    else $error("status changed while idle");
  a_count_range: assert property (cnt_q <= DBGTR_FIFO_DEPTH)
    else $error("valid count above depth");
  a_secure_enable: assert property (secure && !ctl_q[DBGTR_CTL_EN] |=> !ctl_q[DBGTR_CTL_EN])
    else $error("enable set while secure");
  a_event_high_zero: assert property (fifo_wr.valid && event_only |->
      fifo_wr.word[15:8] == DBGTR_HIGH_UNUSED)
    else $error("high byte used in event-only mode");
  a_break_cause: assert property (brk_req |-> $past(ctl_q[DBGTR_CTL_BRK]) && !running)
    else $error("break without enable or run end");
  a_full_ends: assert property (begin_mode && full_now && !sw_stop |=>
      st_q == DBGTR_ST_IDLE && cnt_q == DBGTR_FIFO_DEPTH)
    else $error("full fifo did not end begin trace");

  c_run_start: cover property (start);
  c_trigger_end: cover property (running && !begin_mode && trig);
  c_full_end: cover property (begin_mode && full_now);
  c_sw_stop: cover property (sw_stop);

endmodule

// ===== tb/dbgtr_host.sv
`timescale 1ns/100ps
module dbgtr_host
  import dbgtr_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // wishbone master side
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i,
  // capture fifo writes seen by the host
  input wire dbgtr_fifo_wr_t fifo_wr
);
  int words_seen = 0;

  // idle bus from time zero
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
  end

  // own readout count
  // the device never decrements its count on readout, so the host keeps its own tally
  always @(posedge clk_sys) begin
    if (fifo_wr.valid === 1'b1) words_seen <= words_seen + 1;
  end

  // one classic cycle; request held until ack is sampled high
  // no local limit: a stuck slave is left to the bench watchdog
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                      output logic [7:0] rd);
    @(posedge clk_sys);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= adr;
    wb_sel_o <= 4'h1;
    wb_dat_o <= {24'h000000, wd};
    do begin
      @(posedge clk_sys);
    end while (wb_ack_i !== 1'b1);
    rd = wb_dat_i[7:0];
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
  endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/100ps
module tb
  import dbgtr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  dbgtr_bus_obs_t bus_obs = '0;
  logic exec_valid = 1'b0;
  logic [15:0] exec_addr = 16'h0000;
  logic [15:0] cmp_a_val = 16'h1000;
  logic [15:0] cmp_b_val = 16'h2033;
  logic secure = 1'b0;
  logic wb_cyc, wb_stb, wb_we, wb_ack, brk_req, brk_tag;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w, wb_dat_r;
  dbgtr_fifo_wr_t fifo_wr;
  int fails = 0;
  int samples_checked = 0;
  int brk_seen = 0;
  logic [15:0] last_word = 16'h0000;
  // mode, first address, second address, data, trigger expected
  logic [44:0] rows [13] = '{
    {4'h0, 16'h1000, 16'h1000, 8'h00, 1'b1}, {4'h1, 16'h2033, 16'h2033, 8'h00, 1'b1},
    {4'h2, 16'h2033, 16'h1000, 8'h00, 1'b0}, {4'h2, 16'h1000, 16'h2033, 8'h00, 1'b1},
    {4'h5, 16'h1000, 16'h1000, 8'h33, 1'b1}, {4'h5, 16'h1000, 16'h1000, 8'h34, 1'b0},
    {4'h6, 16'h1000, 16'h1000, 8'h34, 1'b1}, {4'h7, 16'h1800, 16'h1800, 8'h00, 1'b1},
    {4'h7, 16'h2034, 16'h2034, 8'h00, 1'b0}, {4'h8, 16'h0fff, 16'h0fff, 8'h00, 1'b1},
    {4'h8, 16'h2033, 16'h2033, 8'h00, 1'b0}, {4'h9, 16'h1000, 16'h1000, 8'h00, 1'b0},
    {4'hf, 16'h1000, 16'h1000, 8'h00, 1'b0}};

  dbgtr_core dut (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
    .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .bus_obs(bus_obs), .exec_valid(exec_valid),
    .exec_addr(exec_addr), .cmp_a_val(cmp_a_val), .cmp_b_val(cmp_b_val), .secure(secure),
    .fifo_wr(fifo_wr), .brk_req(brk_req), .brk_tag(brk_tag));

  dbgtr_host host (.clk_sys(clk_sys), .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we),
    .wb_adr_o(wb_adr), .wb_sel_o(wb_sel), .wb_dat_o(wb_dat_w), .wb_dat_i(wb_dat_r),
    .wb_ack_i(wb_ack), .fifo_wr(fifo_wr));

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  // break pulses and the last stored word
  always @(posedge clk_sys) begin
    if (brk_req === 1'b1) brk_seen <= brk_seen + 1;
    if (fifo_wr.valid === 1'b1) last_word <= fifo_wr.word;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    host.xfer(1'b0, a, 8'h00, d);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    chk8(d, exp, what);
  endtask
  // n back-to-back observed cpu reads at one address
  task automatic cpu(input logic [15:0] a, input logic [7:0] d, input int n);
    repeat (n) begin
      @(posedge clk_sys);
      bus_obs <= '{valid: 1'b1, rd: 1'b1, addr: a, data: d};
    end
    @(posedge clk_sys);
    bus_obs.valid <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk(DBGTR_OFS_CONTROL, 8'h00, "control reset");
    rchk(DBGTR_OFS_TRIGGER, 8'h00, "trigger reset");
    rchk(DBGTR_OFS_STATUS, 8'h00, "status reset");
    wr(DBGTR_OFS_STATUS, 8'hff);
    rchk(DBGTR_OFS_STATUS, 8'h00, "status write");
    rchk(8'h0c, 8'h00, "unmapped read");
    wr(DBGTR_OFS_TRIGGER, 8'hff);
    rchk(DBGTR_OFS_TRIGGER, 8'hcf, "trigger mask");
    wr(DBGTR_OFS_CONTROL, 8'hc0);
    wr(DBGTR_OFS_TRIGGER, 8'h00);
    rchk(DBGTR_OFS_TRIGGER, 8'hcf, "trigger locked");
    wr(DBGTR_OFS_CONTROL, 8'h80);
  endtask

  task automatic t_end_trace();
    int b0;
    b0 = brk_seen;
    wr(DBGTR_OFS_TRIGGER, 8'h00);
    wr(DBGTR_OFS_CONTROL, 8'hf0);
    rchk(DBGTR_OFS_STATUS, 8'h20, "armed");
    chk8({7'h00, brk_tag}, 8'h01, "tag level");
    cpu(16'h3000, 8'h00, 10);
    cpu(16'h1000, 8'h00, 1);
    repeat (4) @(posedge clk_sys);
    chk8(8'(brk_seen - b0), 8'h01, "break pulses");
    rchk(DBGTR_OFS_STATUS, 8'h88, "end trace status");
    rchk(DBGTR_OFS_STATUS, 8'h88, "count kept");
    rchk(DBGTR_OFS_CONTROL, 8'hb0, "arm cleared");
  endtask

  task automatic t_begin_trace();
    int w0;
    int b0;
    w0 = host.words_seen;
    b0 = brk_seen;
    wr(DBGTR_OFS_TRIGGER, 8'h41);
    wr(DBGTR_OFS_CONTROL, 8'hd0);
    cpu(16'h3000, 8'h00, 3);
    repeat (2) @(posedge clk_sys);
    chk8(8'(host.words_seen - w0), 8'h00, "stored before trigger");
    cpu(16'h2033, 8'h00, 1);
    cpu(16'h3000, 8'h00, 10);
    repeat (3) @(posedge clk_sys);
    chk8(8'(host.words_seen - w0), 8'h08, "begin words");
    chk8(8'(brk_seen - b0), 8'h01, "full break");
    rchk(DBGTR_OFS_STATUS, 8'h48, "begin status");
  endtask

  task automatic t_events();
    int w0;
    w0 = host.words_seen;
    wr(DBGTR_OFS_TRIGGER, 8'h03);
    wr(DBGTR_OFS_CONTROL, 8'hc0);
    cpu(16'h3000, 8'h11, 1);
    cpu(16'h2033, 8'h5a, 1);
    repeat (2) @(posedge clk_sys);
    chk8(8'(host.words_seen - w0), 8'h01, "event words");
    chk16(last_word, 16'h005a, "event word");
    wr(DBGTR_OFS_CONTROL, 8'h80);
    rchk(DBGTR_OFS_STATUS, 8'h41, "software stop");
    wr(DBGTR_OFS_TRIGGER, 8'h04);
    wr(DBGTR_OFS_CONTROL, 8'hc0);
    cpu(16'h2033, 8'h66, 1);
    cpu(16'h1000, 8'h00, 1);
    cpu(16'h2033, 8'h77, 1);
    repeat (2) @(posedge clk_sys);
    chk8(8'(host.words_seen - w0), 8'h02, "a then events");
    wr(DBGTR_OFS_CONTROL, 8'h80);
  endtask

  task automatic t_modes();
    logic [44:0] r;
    logic [7:0] s;
    for (int i = 0; i < 13; i++) begin
      r = rows[i];
      wr(DBGTR_OFS_TRIGGER, {4'h0, r[44:41]});
      wr(DBGTR_OFS_CONTROL, 8'hc0);
      cpu(r[40:25], r[8:1], 1);
      cpu(r[24:9], r[8:1], 1);
      repeat (2) @(posedge clk_sys);
      rd(DBGTR_OFS_STATUS, s);
      chk8(s & 8'h20, r[0] ? 8'h00 : 8'h20, "mode trigger");
      wr(DBGTR_OFS_CONTROL, 8'h80);
    end
  endtask

  task automatic t_tag();
    logic [7:0] s;
    wr(DBGTR_OFS_TRIGGER, 8'h80);
    wr(DBGTR_OFS_CONTROL, 8'hc0);
    cpu(16'h1000, 8'h00, 1);
    repeat (2) @(posedge clk_sys);
    rd(DBGTR_OFS_STATUS, s);
    chk8(s & 8'h20, 8'h20, "tag waits");
    @(posedge clk_sys);
    exec_valid <= 1'b1;
    exec_addr <= 16'h1000;
    @(posedge clk_sys);
    exec_valid <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(DBGTR_OFS_STATUS, s);
    chk8(s & 8'h20, 8'h00, "tag fires");
  endtask

  // comparator A limited to writes ignores reads, then a read filter matches
  task automatic t_rw_filter();
    logic [7:0] s;
    wr(DBGTR_OFS_TRIGGER, 8'h00);
    wr(DBGTR_OFS_CONTROL, 8'hc4);
    cpu(16'h1000, 8'h00, 1);
    repeat (2) @(posedge clk_sys);
    rd(DBGTR_OFS_STATUS, s);
    chk8(s & 8'he0, 8'h20, "read filtered out");
    wr(DBGTR_OFS_CONTROL, 8'hcc);
    cpu(16'h1000, 8'h00, 1);
    repeat (2) @(posedge clk_sys);
    rd(DBGTR_OFS_STATUS, s);
    chk8(s & 8'he0, 8'h80, "read matches");
  endtask

  task automatic t_secure();
    wr(DBGTR_OFS_CONTROL, 8'h00);
    secure <= 1'b1;
    wr(DBGTR_OFS_CONTROL, 8'h80);
    rchk(DBGTR_OFS_CONTROL, 8'h00, "secure enable");
    secure <= 1'b0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_end_trace();
    t_begin_trace();
    t_events();
    t_modes();
    t_tag();
    t_rw_filter();
    t_secure();
    complete_run();
  end

  // watchdog well beyond the expected several hundred cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    complete_run();
  end
endmodule
